// ==== verilog/irt_timer.sv ====
// Twelve-bit infrared carrier timer: carrier PWM, capture and envelope detect.
// Assumes synchronous receiver inputs and a register master with one-cycle strobes.
// What this block does
// [R1] Capture mode counts upward from zero on the divided clock.
// [R2] Capture edge stores counter as width, raises capture flag, clears counter.
// [R3] Counter wrap past all-ones raises the overflow flag.
// [R4] Control bit six picks capture edge: zero rising, one falling.
// [R5] Software counts overflows when a period exceeds twelve bits.
// [R6] Software measures the period first, then preloads all-ones minus 1.5 periods.
// [R7] First envelope edge raises envelope flag, sets present, reloads, starts.
// [R8] Later envelope edges reload the counter and keep present at one.
// [R9] Envelope overflow raises envelope flag and clears present.
// [R10] Control bit seven enables the timer.
// [R11] Control bits five to four pick divide by sixteen, four or one.
// [R12] Control bits three to two pick duty one third to one sixth.
// [R13] Control bits one to zero pick carrier, level, capture or envelope mode.
// [R14] Low count address reads live counter, writes preload low byte.
// [R15] High count address uses bits three to zero; upper bits read zero.
// [R16] Same addresses hold a readable, writable twelve-bit PWM period.
// [R17] Same addresses hold the captured width, read-write, reset to zero.
// [R18] Software computes preload as 4096 minus clock over carrier times duty.
// [R19] Software writes preload before the control write that enables.
// [R20] PWM overflow reloads the counter from preload and keeps counting.
// [R21] The enable bit switches the carrier at the output directly.
// [R22] Capture source bit picks the LED pad receiver or port C bit three.
// [R23] While disabled the counter holds and no events occur.
module irt_timer
  import irt_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Receiver inputs
  input  wire logic       rx_pad,
  input  wire logic       rx_portc3,
  // LED drive and status
  output logic            led_out,
  output logic            envelope_present_status,
  output logic      [2:0] event_flags
);

  if (CNT_W < 9 || CNT_W > 8 + HI_FIELD_W) begin : g_chk
    $error("irt_timer: CNT_W must lie between 9 and 12");
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       timer_control;
    logic [CNT_W-1:0] preload;
    logic [CNT_W-1:0] width;
    logic [CNT_W-1:0] count;
    logic             capture_interrupt_flag;
    logic             overflow_interrupt_flag;
    logic             envelope_interrupt_flag;
    logic             envelope_present;
    logic             capture_source_select;
    logic [2:0]       phase;
    logic             rx_prev;
    logic             enable_prev;
    logic             led;
    logic [7:0]       rdata;
  } irt_timer_state_s;

  irt_timer_state_s st_r;
  irt_timer_state_s st_nxt;

  logic             tick;
  logic             timer_enable_bit;
  logic             capture_edge_select;
  logic [1:0]       clock_divider_select;
  logic [1:0]       carrier_duty_select;
  logic [1:0]       operating_mode_select;
  logic             rx_in;
  logic             rx_edge;
  logic             at_max;
  logic             started;
  logic [2:0]       phase_last;

  assign timer_enable_bit      = st_r.timer_control[CTRL_ENABLE_BIT];                  // [R10]
  assign capture_edge_select   = st_r.timer_control[CTRL_EDGE_BIT];
  assign clock_divider_select  = st_r.timer_control[CTRL_CLK_LSB +: 2];
  assign carrier_duty_select   = st_r.timer_control[CTRL_DUTY_LSB +: 2];
  assign operating_mode_select = st_r.timer_control[CTRL_MODE_LSB +: 2];
  assign rx_in      = st_r.capture_source_select ? rx_portc3 : rx_pad;                 // [R22]
  // Rising when the edge select is zero, falling when it is one
  assign rx_edge    = (rx_in != st_r.rx_prev) && (rx_in == !capture_edge_select);      // [R4]
  assign at_max     = (st_r.count == {CNT_W{1'b1}});
  assign started    = timer_enable_bit && !st_r.enable_prev;
  // Carrier period spans duty+3 overflow intervals, high for the first one
  assign phase_last = {1'b0, carrier_duty_select} + DUTY_LAST_BASE;                    // [R12]

  // --------------------------------------------------------------------
  // Clock prescaler
  // --------------------------------------------------------------------
  irt_prescaler #(
    .DIV_W (4)
  ) u_presc (
    .clk     (clk),
    .arst_n  (arst_n),
    .run     (timer_enable_bit),
    .clk_sel (clock_divider_select),                                                   // [R11]
    .tick    (tick)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt             = st_r;
    st_nxt.rdata       = BYTE_RESET;
    st_nxt.rx_prev     = rx_in;
    st_nxt.enable_prev = timer_enable_bit;

    // Register reads: data stands in the cycle after the strobe only
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONTROL: begin
          st_nxt.rdata = st_r.timer_control;
        end
        ADDR_STATUS: begin
          st_nxt.rdata[STAT_ENV_BIT]   = st_r.envelope_present;
          st_nxt.rdata[STAT_ENVIF_BIT] = st_r.envelope_interrupt_flag;
          st_nxt.rdata[STAT_OVFIF_BIT] = st_r.overflow_interrupt_flag;
          st_nxt.rdata[STAT_CAPTURE_INTERRUPT_FLAG_BIT] = st_r.capture_interrupt_flag;
        end
        ADDR_RX_CONFIG: begin
          st_nxt.rdata[RXCFG_SRC_BIT] = st_r.capture_source_select;
        end
        ADDR_COUNT_LO: begin
          if (operating_mode_select == MODE_CAPTURE) begin
            st_nxt.rdata = st_r.width[7:0];                                            // [R17]
          end else if (timer_enable_bit) begin
            st_nxt.rdata = st_r.count[7:0];                                            // [R14]
          end else begin
            st_nxt.rdata = st_r.preload[7:0];                                          // [R16]
          end
        end
        ADDR_COUNT_HI: begin
          // Upper four bits stay zero
          if (operating_mode_select == MODE_CAPTURE) begin
            st_nxt.rdata = 8'(st_r.width[CNT_W-1:8]);                                  // [R17]
          end else if (timer_enable_bit) begin
            st_nxt.rdata = 8'(st_r.count[CNT_W-1:8]);                                  // [R15]
          end else begin
            st_nxt.rdata = 8'(st_r.preload[CNT_W-1:8]);                                // [R16]
          end
        end
        default: begin
          st_nxt.rdata = BYTE_RESET;
        end
      endcase
    end

    // Register writes; flag clears come first so a same-cycle event wins
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CONTROL: begin
          st_nxt.timer_control = reg_wdata;                                            // [R13]
        end
        ADDR_STATUS: begin
          // Write one to clear a flag
          if (reg_wdata[STAT_ENVIF_BIT]) begin
            st_nxt.envelope_interrupt_flag = 1'b0;
          end
          if (reg_wdata[STAT_OVFIF_BIT]) begin
            st_nxt.overflow_interrupt_flag = 1'b0;
          end
          if (reg_wdata[STAT_CAPTURE_INTERRUPT_FLAG_BIT]) begin
            st_nxt.capture_interrupt_flag = 1'b0;
          end
        end
        ADDR_RX_CONFIG: begin
          st_nxt.capture_source_select = reg_wdata[RXCFG_SRC_BIT];
        end
        ADDR_COUNT_LO: begin
          st_nxt.preload[7:0] = reg_wdata;                                             // [R14] [R16]
          st_nxt.width[7:0]   = reg_wdata;                                             // [R17]
        end
        ADDR_COUNT_HI: begin
          st_nxt.preload[CNT_W-1:8] = reg_wdata[CNT_W-9:0];                            // [R15] [R16]
          st_nxt.width[CNT_W-1:8]   = reg_wdata[CNT_W-9:0];                            // [R17]
        end
        default: begin
        end
      endcase
    end

    // Counter and events; nothing moves while disabled
    if (!timer_enable_bit) begin
      st_nxt.phase = 3'h0;                                                             // [R23]
    end else if (started) begin
      // Capture starts from zero; envelope waits at preload for its first edge
      st_nxt.count = (operating_mode_select == MODE_CAPTURE) ? '0 : st_r.preload;      // [R1] [R19]
      st_nxt.phase = 3'h0;
      if (operating_mode_select == MODE_ENVELOPE) begin
        st_nxt.envelope_present = 1'b0;
      end
    end else begin
      unique case (operating_mode_select)
        MODE_CAPTURE: begin
          if (rx_edge) begin
            st_nxt.width                  = st_r.count;                                // [R2]
            st_nxt.capture_interrupt_flag = 1'b1;                                      // [R2]
            st_nxt.count                  = '0;                                        // [R2]
          end else if (tick) begin
            st_nxt.count = st_r.count + CNT_W'(1);                                     // [R1]
            if (at_max) begin
              st_nxt.overflow_interrupt_flag = 1'b1;                                   // [R3] [R5]
            end
          end
        end
        MODE_ENVELOPE: begin
          if (rx_edge) begin
            if (!st_r.envelope_present) begin
              st_nxt.envelope_interrupt_flag = 1'b1;                                   // [R7]
            end
            st_nxt.envelope_present = 1'b1;                                            // [R7] [R8]
            st_nxt.count            = st_r.preload;                                    // [R7] [R8] [R6]
          end else if (tick && st_r.envelope_present) begin
            st_nxt.count = st_r.count + CNT_W'(1);
            if (at_max) begin
              // Carrier missing for longer than the preloaded window
              st_nxt.envelope_interrupt_flag = 1'b1;                                   // [R9]
              st_nxt.overflow_interrupt_flag = 1'b1;                                   // [R3]
              st_nxt.envelope_present        = 1'b0;                                   // [R9]
            end
          end
        end
        default: begin
          if (tick) begin
            if (at_max) begin
              st_nxt.count                   = st_r.preload;                           // [R20] [R18]
              st_nxt.overflow_interrupt_flag = 1'b1;                                   // [R3]
              st_nxt.phase = (st_r.phase >= phase_last) ? 3'h0 : st_r.phase + 3'h1;    // [R12]
            end else begin
              st_nxt.count = st_r.count + CNT_W'(1);
            end
          end
        end
      endcase
    end

    // LED drive follows the enable directly
    st_nxt.led = st_nxt.timer_control[CTRL_ENABLE_BIT] &&                              // [R21]
                 ((st_nxt.timer_control[CTRL_MODE_LSB +: 2] == MODE_PWM_LEVEL) ||
                  ((st_nxt.timer_control[CTRL_MODE_LSB +: 2] == MODE_PWM_CARRIER) &&
                   (st_nxt.phase == 3'h0)));
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r               <= '0;
      st_r.timer_control <= CONTROL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata               = st_r.rdata;
  assign led_out                 = st_r.led;
  assign envelope_present_status = st_r.envelope_present;
  assign event_flags             = {st_r.envelope_interrupt_flag,
                                    st_r.overflow_interrupt_flag,
                                    st_r.capture_interrupt_flag};

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic cap_event;
  logic env_timeout;
  logic pwm_wrap;
  assign cap_event   = timer_enable_bit && !started && rx_edge &&
                       (operating_mode_select == MODE_CAPTURE);
  assign env_timeout = timer_enable_bit && !started && !rx_edge && tick && at_max &&
                       st_r.envelope_present && (operating_mode_select == MODE_ENVELOPE);
  assign pwm_wrap    = timer_enable_bit && !started && tick && at_max &&
                       !operating_mode_select[1];

  AST_CAP_CLEAR: assert property (cap_event |=> st_r.count == '0)                      // [R2]
    else $error("capture edge did not clear the counter");
  AST_CAP_WIDTH: assert property (cap_event |=> st_r.width == $past(st_r.count))       // [R2]
    else $error("capture width differs from counter at the edge");
  AST_CAP_FLAG: assert property (cap_event |=> event_flags[0] ##1 1'b1)                // [R2]
    else $error("capture flag not raised");
  AST_HOLD: assert property (!timer_enable_bit && !reg_wr |=> st_r.count == $past(st_r.count)) // [R23]
    else $error("counter moved while disabled");
  AST_ENV_LOST: assert property (env_timeout |=> !envelope_present_status && event_flags[2]) // [R9]
    else $error("envelope timeout handled wrongly");
  AST_ENV_FIRST: assert property (timer_enable_bit && !started && rx_edge && !st_r.envelope_present && // [R7]
      (operating_mode_select == MODE_ENVELOPE) |=> envelope_present_status && event_flags[2]
      && st_r.count == $past(st_r.preload))
    else $error("first envelope edge handled wrongly");
  AST_ENV_NEXT: assert property (timer_enable_bit && !started && rx_edge && st_r.envelope_present && // [R8]
      (operating_mode_select == MODE_ENVELOPE) |=> envelope_present_status && st_r.count == $past(st_r.preload))
    else $error("later envelope edge handled wrongly");
  AST_PWM_RELOAD: assert property (pwm_wrap && !reg_wr |=> st_r.count == $past(st_r.preload) // [R20]
      && event_flags[1])
    else $error("PWM overflow did not reload the counter");
  AST_LED_OFF: assert property (!timer_enable_bit && !reg_wr |=> !led_out)             // [R21]
    else $error("LED driven while timer disabled");
  AST_HI_READ: assert property (reg_rd && reg_addr == ADDR_COUNT_HI |=> reg_rdata[7:4] == 4'h0) // [R15]
    else $error("reserved high bits read nonzero");
  AST_RD_ONCE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stands outside its cycle");

endmodule : irt_timer

// ==== verilog/irt_pkg.sv ====
// Constants shared by the infrared carrier timer and its clock prescaler.
// Assumes an 8-bit register port and a single 10 MHz system clock.
package irt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_CONFIG = 8'h11;
  localparam logic [7:0] ADDR_STATUS    = 8'h16;
  localparam logic [7:0] ADDR_CONTROL   = 8'h21;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'h23;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_EDGE_BIT   = 6;
  localparam int unsigned CTRL_CLK_LSB    = 4;
  localparam int unsigned CTRL_DUTY_LSB   = 2;
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned STAT_ENV_BIT    = 7;
  localparam int unsigned STAT_ENVIF_BIT  = 2;
  localparam int unsigned STAT_OVFIF_BIT  = 1;
  localparam int unsigned STAT_CAPTURE_INTERRUPT_FLAG_BIT  = 0;
  localparam int unsigned RXCFG_SRC_BIT   = 2;
  localparam int unsigned HI_FIELD_W      = 4;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_PWM_CARRIER = 2'h0;
  localparam logic [1:0] MODE_PWM_LEVEL   = 2'h1;
  localparam logic [1:0] MODE_CAPTURE     = 2'h2;
  localparam logic [1:0] MODE_ENVELOPE    = 2'h3;
  localparam logic [1:0] CLK_SEL_DIV16    = 2'h3;
  localparam logic [1:0] CLK_SEL_DIV4     = 2'h2;
  localparam logic [3:0] DIV16_LAST       = 4'hf;
  localparam logic [3:0] DIV4_LAST        = 4'h3;
  localparam logic [2:0] DUTY_LAST_BASE   = 3'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET    = 8'h00;

endpackage : irt_pkg

// ==== verilog/irt_prescaler.sv ====
// Clock-enable divider for the carrier timer: one tick per 1, 4 or 16 clocks.
// Assumes run and clk_sel are register outputs of the same clock domain.
module irt_prescaler
  import irt_pkg::*;
#(
  parameter int unsigned DIV_W = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  // Enable pulse
  output logic            tick
);

  if (DIV_W < 4) begin : g_chk
    $error("irt_prescaler: DIV_W must hold a divide by sixteen");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } irt_presc_state_s;

  irt_presc_state_s st_r;
  irt_presc_state_s st_nxt;
  logic [DIV_W-1:0] last_count;

  always_comb begin
    st_nxt = st_r;
    unique case (clk_sel)
      CLK_SEL_DIV16: last_count = DIV_W'(DIV16_LAST);
      CLK_SEL_DIV4:  last_count = DIV_W'(DIV4_LAST);
      default:       last_count = '0;
    endcase
    st_nxt.tick = 1'b0;
    if (!run) begin
      // Restart the phase so the first tick after enable is a full period
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= last_count) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : irt_prescaler

// ==== dv/irt_ir_frontend.sv ====
// Model of the infrared receiver output and LED driver load beside the carrier timer.
// Assumes the bench changes run, half and on_c3 only while no burst is running.
module irt_ir_frontend (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Burst control
  input  wire logic        run,
  input  wire logic [8:0]  half,
  input  wire logic        on_c3,
  input  wire logic        cnt_clr,
  // Pins
  input  wire logic        led_out,
  output logic             rx_pad,
  output logic             rx_portc3,
  // LED activity
  output logic      [15:0] led_high_cnt,
  output logic      [15:0] led_rise_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] ph_r;
  logic       car_r;
  logic       led_d_r;
  // Comparator output rests low with no light, so the idle line is a real low
  assign rx_pad    = car_r & ~on_c3;
  assign rx_portc3 = car_r & on_c3;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r         <= '0;
      car_r        <= 1'b0;
      led_d_r      <= 1'b0;
      led_high_cnt <= '0;
      led_rise_cnt <= '0;
    end else begin
      led_d_r <= led_out;
      if (!run) begin
        ph_r  <= '0;
        car_r <= 1'b0;
      end else if (ph_r == 9'h000) begin
        ph_r  <= half - 9'h001;
        car_r <= ~car_r;
      end else begin
        ph_r <= ph_r - 9'h001;
      end
      if (cnt_clr) begin
        led_high_cnt <= '0;
        led_rise_cnt <= '0;
      end else begin
        led_high_cnt <= led_high_cnt + 16'(led_out);
        led_rise_cnt <= led_rise_cnt + 16'(led_out & ~led_d_r);
      end
    end
  end
endmodule : irt_ir_frontend

// ==== dv/tb_top.sv ====
// Self-checking bench for the infrared carrier timer with a receiver model.
// Assumes the register port answers reads one cycle after the strobe.
module tb_top import irt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, reg_wr, reg_rd, rx_pad, rx_portc3, led_out, envelope_present_status;
  logic run, on_c3, cnt_clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, lo;
  logic [2:0] event_flags;
  logic [8:0] half;
  logic [15:0] led_high_cnt, led_rise_cnt, w, d, e;
  int errors, samples_checked, cycles, i;

  irt_timer #(.CNT_W(12)) uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pad(rx_pad), .rx_portc3(rx_portc3),
    .led_out(led_out), .envelope_present_status(envelope_present_status), .event_flags(event_flags));
  irt_ir_frontend ir_fe (.clk(clk), .arst_n(arst_n), .run(run), .half(half), .on_c3(on_c3),
    .cnt_clr(cnt_clr), .led_out(led_out), .rx_pad(rx_pad), .rx_portc3(rx_portc3),
    .led_high_cnt(led_high_cnt), .led_rise_cnt(led_rise_cnt));

  // ----------------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 dat = reg_rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo_v, input logic [15:0] hi_v);
    samples_checked++;
    if ((got >= lo_v && got <= hi_v) !== 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo_v, hi_v);
    end
  endtask : chk_rng
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole sequence needs about 20000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, run, on_c3, cnt_clr} = '0;
    {reg_addr, reg_wdata} = '0;
    half = 9'd160;
    {errors, samples_checked, cycles} = '0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_CONTROL, rv); chk(16'(rv), 16'(CONTROL_RESET));
    rd(ADDR_COUNT_LO, rv); chk(16'(rv), 16'(BYTE_RESET));
    rd(ADDR_COUNT_HI, rv); chk(16'(rv), 16'(BYTE_RESET));
    // Capture mode reads the width, which must also come out of reset as zero
    wr(ADDR_CONTROL, {6'h00, MODE_CAPTURE});
    rd(ADDR_COUNT_LO, rv); chk(16'(rv), 16'(BYTE_RESET));
    rd(ADDR_COUNT_HI, rv); chk(16'(rv), 16'(BYTE_RESET));
    wr(ADDR_CONTROL, CONTROL_RESET);
    wr(8'h30, 8'h5a);
    rd(8'h30, rv); chk(16'(rv), 16'h0000);
    wr(ADDR_COUNT_LO, 8'hde);
    wr(ADDR_COUNT_HI, 8'hff);
    rd(ADDR_COUNT_LO, rv); chk(16'(rv), 16'h00de);
    rd(ADDR_COUNT_HI, rv); chk(16'(rv), 16'h000f);
    $display("test registers done");
    // Stopped timer sees a full carrier and a full wrap time yet reports nothing
    wr(ADDR_CONTROL, {6'h00, MODE_CAPTURE});
    @(posedge clk) run <= 1'b1;
    cyc(4200); chk(16'(event_flags), 16'h0000);
    @(posedge clk) run <= 1'b0;
    on_c3 <= 1'b1;
    wr(ADDR_CONTROL, {1'b1, 5'h00, MODE_CAPTURE});
    @(posedge clk) run <= 1'b1;
    cyc(400); chk(16'(event_flags[0]), 16'h0000);
    $display("test idle done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk) run <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_STATUS, 8'h07);
      on_c3 <= i[1];
      wr(ADDR_RX_CONFIG, {5'h00, i[1], 2'h0});
      wr(ADDR_CONTROL, {1'b1, i[0], i[1:0], 2'h0, MODE_CAPTURE});
      cyc(3);
      @(posedge clk) run <= 1'b1;
      // First burst edge rises at once; the first fall comes half a period later
      cyc(6); chk(16'(event_flags[0]), 16'(!i[0]));
      cyc(700);
      rd(ADDR_COUNT_LO, lo);
      rd(ADDR_COUNT_HI, rv); chk(16'(rv[7:4]), 16'h0000);
      w = {4'h0, rv[3:0], lo};
      d = (i == 3) ? 16'd16 : (i == 2) ? 16'd4 : 16'd1;
      e = 16'd320 / d;
      chk_rng(w, e - 16'd1, e);
    end
    $display("test capture done");
    @(posedge clk) run <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h07);
    wr(ADDR_CONTROL, {1'b1, 5'h00, MODE_CAPTURE});
    cyc(4000); chk(16'(event_flags[1]), 16'h0000);
    cyc(110); chk(16'(event_flags[1]), 16'h0001);
    rd(ADDR_STATUS, rv); chk(16'(rv[STAT_OVFIF_BIT]), 16'h0001);
    $display("test overflow done");
    // Envelope: carrier period 40 clocks, preload all-ones minus 1.5 periods
    half <= 9'd20;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h07);
    wr(ADDR_COUNT_LO, 8'hc3);
    wr(ADDR_COUNT_HI, 8'h0f);
    wr(ADDR_CONTROL, {1'b1, 5'h00, MODE_ENVELOPE});
    cyc(100); chk(16'({envelope_present_status, event_flags}), 16'h0000);
    @(posedge clk) run <= 1'b1;
    cyc(5); chk(16'({envelope_present_status, event_flags[2]}), 16'h0003);
    wr(ADDR_STATUS, 8'h04);
    cyc(400); chk(16'({envelope_present_status, event_flags[1]}), 16'h0002);
    @(posedge clk) run <= 1'b0;
    cyc(15); chk(16'(envelope_present_status), 16'h0001);
    cyc(60); chk(16'({envelope_present_status, event_flags[2:1]}), 16'h0003);
    $display("test envelope done");
    // Carrier: ten counts an interval, high one interval in duty_code plus three
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LO, 8'hf6);
    wr(ADDR_COUNT_HI, 8'h0f);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, {2'h2, 2'h0, i[1:0], (i == 4) ? MODE_PWM_LEVEL : MODE_PWM_CARRIER});
      cyc(50);
      @(posedge clk) cnt_clr <= 1'b1;
      @(posedge clk) cnt_clr <= 1'b0;
      cyc(1200);
      e = (i == 4) ? 16'd1200 : 16'd1200 / 16'(i + 3);
      chk_rng(led_high_cnt, e - 16'd12, e + 16'd12);
      e = (i == 4) ? 16'd0 : e / 16'd10;
      chk_rng(led_rise_cnt, e - 16'(i != 4), e + 16'(i != 4));
    end
    chk(16'(event_flags[1]), 16'h0001);
    wr(ADDR_CONTROL, 8'h00);
    cyc(3); chk(16'(led_out), 16'h0000);
    $display("test carrier done");
    tally_and_finish();
  end
endmodule : tb_top
